// *** design/pra_lane.sv ***
// Per-lane status tracker
`timescale 1ns/1ps
module pra_lane
  import pra_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input pra_pkg::pra_lane_in_t lane_in,
  output pra_pkg::pra_lane_st_t lane_st
);

  pra_lane_st_t st_ff;
  pra_lane_st_t nxt_st;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.synced = lane_in.word_sync & lane_in.marker_seen;
    nxt_st.lock = lane_in.block_lock;
    nxt_st.mf_err = lane_in.marker_bad;
    // Sticky: arming must survive later bad markers
    nxt_st.good_once = st_ff.good_once | lane_in.marker_good;
    nxt_st.idx = lane_in.phys_idx;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '{synced: PRA_RST_LVL, lock: PRA_RST_LVL, mf_err: PRA_RST_LVL,
                 good_once: PRA_RST_LVL, idx: PRA_RST_IDX};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lane_st = st_ff;

endmodule

// *** design/pra_pkg.sv ***
// Package for the receive lane alignment status block
// Contract
// - Each lane's marker word error bit pulses high one cycle per malformed marker, back to back allowed.
// - The aligned output is high exactly while all lanes are aligned and deskewed.
// - A low aligned output is reported as a local fault, except in reset, where both are low.
// - PCS status is high only when aligned and not in the high bit error rate state.
// - Each block lock bit is high while its lane holds block lock.
// - The alignment error level rises when alignment or deskew fails or an earlier alignment is lost.
// - The misalignment output pulses one cycle when the aligner misses the expected marker on all lanes.
// - No misalignment pulse until every lane saw a good marker once and a bad marker followed.
// - The misalignment pulse comes one meta-frame after the offending marker error.
// - Without any correct marker ever seen, lane problems show only on the per-lane error vector.
// - The remote fault level is high while a remote fault is detected and low otherwise.
// - Twenty 5-bit buses give the physical lane that carries each PCS lane.
// - A physical index bus is meaningful only while its lane's word sync bit is high.
// - A lane's word sync bit is set once it has word sync and has received a lane marker.
package pra_pkg;

  // ----------------------------------------
  // Sizes and reset values
  // ----------------------------------------
  localparam int PRA_LANES = 20;
  localparam int PRA_IDX_W = 5;
  localparam logic PRA_RST_LVL = 1'h0;
  localparam logic [PRA_IDX_W-1:0] PRA_RST_IDX = 5'h00;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic word_sync;
    logic marker_seen;
    logic block_lock;
    logic marker_bad;
    logic marker_good;
    logic [PRA_IDX_W-1:0] phys_idx;
  } pra_lane_in_t;

  typedef struct packed {
    logic synced;
    logic lock;
    logic mf_err;
    logic good_once;
    logic [PRA_IDX_W-1:0] idx;
  } pra_lane_st_t;

  typedef struct packed {
    logic aligned;
    logic local_fault;
    logic status;
    logic aligned_err;
    logic ever_aligned;
    logic bad_seen;
    logic miss_pend;
    logic misaligned;
    logic remote_fault;
  } pra_top_st_t;

endpackage

// *** design/pra_status.sv ***
// Receive lane alignment status top
`timescale 1ns/1ps
module pra_status
  import pra_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input pra_pkg::pra_lane_in_t [pra_pkg::PRA_LANES-1:0] lane_in,
  input wire logic lanes_aligned,
  input wire logic lanes_deskewed,
  input wire logic align_fail,
  input wire logic aligner_marker_miss,
  input wire logic metaframe_tick,
  input wire logic hi_ber,
  input wire logic remote_fault_det,
  output logic [pra_pkg::PRA_LANES-1:0] lane_marker_word_error,
  output logic [pra_pkg::PRA_LANES-1:0] lane_block_lock,
  output logic [pra_pkg::PRA_LANES-1:0] lane_word_sync,
  output logic [pra_pkg::PRA_LANES-1:0][pra_pkg::PRA_IDX_W-1:0] pcs_lane_physical_index,
  output logic rx_aligned,
  output logic rx_local_fault,
  output logic rx_status,
  output logic rx_aligned_err,
  output logic rx_misaligned,
  output logic rx_remote_fault
);

  // ----------------------------------------
  // Lane trackers
  // ----------------------------------------
  pra_lane_st_t [PRA_LANES-1:0] lane_st;
  logic [PRA_LANES-1:0] bad_vec;
  logic [PRA_LANES-1:0] lock_vec;
  logic [PRA_LANES-1:0] good_once_vec;
  logic [PRA_LANES-1:0] sync_vec;
  logic [PRA_LANES-1:0][PRA_IDX_W-1:0] idx_vec;

  genvar gi;
  generate
    for (gi = 0; gi < PRA_LANES; gi++) begin : g_lane
      pra_lane u_lane (
        .clk(clk),
        .rstn(rstn),
        .lane_in(lane_in[gi]),
        .lane_st(lane_st[gi])
      );
      assign bad_vec[gi] = lane_in[gi].marker_bad;
      assign lock_vec[gi] = lane_in[gi].block_lock;
      assign good_once_vec[gi] = lane_st[gi].good_once;
      assign sync_vec[gi] = lane_in[gi].word_sync & lane_in[gi].marker_seen;
      assign idx_vec[gi] = lane_in[gi].phys_idx;
      assign lane_marker_word_error[gi] = lane_st[gi].mf_err;
      assign lane_block_lock[gi] = lane_st[gi].lock;
      assign lane_word_sync[gi] = lane_st[gi].synced;
      // Index is driven always; consumers qualify it by word sync
      assign pcs_lane_physical_index[gi] = lane_st[gi].idx;
    end
  endgenerate

  // ----------------------------------------
  // Alignment and fault state
  // ----------------------------------------
  pra_top_st_t st_ff;
  pra_top_st_t nxt_st;
  logic armed;
  logic align_now;
  logic miss_hit;

  // Misalignment is only meaningful once every lane has locked onto a good marker
  assign armed = &good_once_vec;
  assign align_now = lanes_aligned & lanes_deskewed;
  assign miss_hit = aligner_marker_miss & armed & (st_ff.bad_seen | (|bad_vec));

  always_comb begin
    nxt_st = st_ff;
    nxt_st.aligned = align_now;
    nxt_st.local_fault = ~align_now;
    nxt_st.status = align_now & ~hi_ber;
    nxt_st.ever_aligned = st_ff.ever_aligned | align_now;
    // High from the loss until realigned; not latched, so a brief loss shows only while it lasts
    nxt_st.aligned_err = align_fail | (st_ff.ever_aligned & ~align_now);
    nxt_st.bad_seen = st_ff.bad_seen | (armed & (|bad_vec));
    // New miss on a tick cycle stays pending: set wins over the clear
    nxt_st.miss_pend = miss_hit | (st_ff.miss_pend & ~metaframe_tick);
    nxt_st.misaligned = st_ff.miss_pend & metaframe_tick;
    nxt_st.remote_fault = remote_fault_det;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '{aligned: PRA_RST_LVL, local_fault: PRA_RST_LVL, status: PRA_RST_LVL,
                 aligned_err: PRA_RST_LVL, ever_aligned: PRA_RST_LVL, bad_seen: PRA_RST_LVL,
                 miss_pend: PRA_RST_LVL, misaligned: PRA_RST_LVL,
                 remote_fault: PRA_RST_LVL};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rx_aligned = st_ff.aligned;
  assign rx_local_fault = st_ff.local_fault;
  assign rx_status = st_ff.status;
  assign rx_aligned_err = st_ff.aligned_err;
  assign rx_misaligned = st_ff.misaligned;
  assign rx_remote_fault = st_ff.remote_fault;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_mf_err_track: assert property (@(posedge clk) disable iff (!rstn)
    rstn ##1 1'b1 |-> lane_marker_word_error == $past(bad_vec))
    else $error("marker word error vector does not follow lane errors");

  chk_aligned_level: assert property (@(posedge clk) disable iff (!rstn)
    align_now |=> rx_aligned ##0 !rx_local_fault)
    else $error("aligned output missing after alignment");

  chk_local_fault: assert property (@(posedge clk) disable iff (!rstn)
    !align_now |=> rx_local_fault && !rx_aligned)
    else $error("local fault not raised while unaligned");

  chk_status_combo: assert property (@(posedge clk) disable iff (!rstn)
    rx_status |-> rx_aligned && !$past(hi_ber))
    else $error("status high while unaligned or in high error state");

  chk_block_lock: assert property (@(posedge clk) disable iff (!rstn)
    lock_vec[0] && lock_vec[19] |=> lane_block_lock[0] && lane_block_lock[19])
    else $error("block lock not reported");

  chk_align_loss: assert property (@(posedge clk) disable iff (!rstn)
    // A realign right after the loss may clear the flag on the second cycle
    (rx_aligned && !align_now) |=> rx_aligned_err ##1 (rx_aligned_err || $past(align_now)))
    else $error("loss of alignment not flagged");

  chk_misalign_armed: assert property (@(posedge clk) disable iff (!rstn)
    rx_misaligned |-> $past(armed, 2) && st_ff.bad_seen)
    else $error("misalignment pulse before arming");

  chk_misalign_tick: assert property (@(posedge clk) disable iff (!rstn)
    (miss_hit && !metaframe_tick) ##1 (!metaframe_tick [*3]) |-> !rx_misaligned)
    else $error("misalignment pulse not held until meta-frame tick");

  chk_misalign_emit: assert property (@(posedge clk) disable iff (!rstn)
    (st_ff.miss_pend && metaframe_tick) |=> rx_misaligned)
    else $error("pending misalignment not emitted at tick");

  chk_remote_fault: assert property (@(posedge clk) disable iff (!rstn)
    remote_fault_det != rx_remote_fault |=> rx_remote_fault == $past(remote_fault_det))
    else $error("remote fault level wrong");

  chk_word_sync: assert property (@(posedge clk) disable iff (!rstn)
    (lane_in[3].word_sync && !lane_in[3].marker_seen) |=> !lane_word_sync[3])
    else $error("word sync set without a lane marker");

  chk_reset_quiet: assert property (@(posedge clk)
    !rstn |-> !rx_misaligned && !rx_aligned && !rx_status && lane_marker_word_error == '0)
    else $error("outputs active during reset");

  // ----------------------------------------
  // Follow checks
  // ----------------------------------------
  // First edge after release still shows reset values, hence the past guard
  chk_quiet_release: assert property (@(posedge clk) disable iff (!rstn)
    !$past(rstn) |-> !rx_misaligned && lane_marker_word_error == '0)
    else $error("pulse emitted on the edge after reset release");

  chk_block_lock_all: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) |-> lane_block_lock == $past(lock_vec))
    else $error("block lock vector does not follow lane lock");

  chk_word_sync_all: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) |-> lane_word_sync == $past(sync_vec))
    else $error("word sync vector does not follow sync and marker");

  chk_index_follow: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) |-> pcs_lane_physical_index == $past(idx_vec))
    else $error("physical index buses do not follow lane map");

  chk_aligned_follow: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) |-> rx_aligned == $past(align_now))
    else $error("aligned output does not follow alignment and deskew");

  chk_fault_inverse: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) |-> rx_local_fault == !rx_aligned)
    else $error("local fault is not the inverse of aligned");

  chk_status_follow: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) |-> rx_status == ($past(align_now) && !$past(hi_ber)))
    else $error("status does not follow alignment and error rate state");

  chk_align_fail_flag: assert property (@(posedge clk) disable iff (!rstn)
    align_fail |=> rx_aligned_err)
    else $error("alignment failure not flagged");

  chk_align_err_clear: assert property (@(posedge clk) disable iff (!rstn)
    (align_now && !align_fail) |=> !rx_aligned_err)
    else $error("alignment error held while aligned");

  chk_misalign_unarmed: assert property (@(posedge clk) disable iff (!rstn)
    !armed |=> !rx_misaligned)
    else $error("misalignment pulse without a good marker on every lane");

  chk_misalign_on_tick: assert property (@(posedge clk) disable iff (!rstn)
    rx_misaligned |-> $past(metaframe_tick))
    else $error("misalignment pulse away from a meta-frame tick");

  chk_pending_kept: assert property (@(posedge clk) disable iff (!rstn)
    miss_hit |=> st_ff.miss_pend)
    else $error("marker miss not held until the next tick");

  chk_pending_clear: assert property (@(posedge clk) disable iff (!rstn)
    (st_ff.miss_pend && metaframe_tick && !miss_hit) |=> !st_ff.miss_pend)
    else $error("pending misalignment not cleared after its pulse");

  chk_remote_follow: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) |-> rx_remote_fault == $past(remote_fault_det))
    else $error("remote fault level does not follow detection");

  cov_misaligned: cover property (@(posedge clk) disable iff (!rstn) rx_misaligned);
  cov_aligned_rise: cover property (@(posedge clk) disable iff (!rstn) $rose(rx_aligned));
  cov_align_err: cover property (@(posedge clk) disable iff (!rstn) $rose(rx_aligned_err));
  cov_status_rise: cover property (@(posedge clk) disable iff (!rstn) $rose(rx_status));
  cov_mf_b2b: cover property (@(posedge clk) disable iff (!rstn)
    lane_marker_word_error[0] ##1 lane_marker_word_error[0]);

endmodule

// *** sim/pra_link_model.sv ***
// Link partner model feeding the per-lane receive inputs
`timescale 1ns/1ps
module pra_link_model
  import pra_pkg::*;
(
  input wire logic [19:0] lock_m,
  input wire logic [19:0] sync_m,
  input wire logic [19:0] mark_m,
  input wire logic [19:0] good_m,
  input wire logic [19:0] bad_m,
  input wire logic [4:0] rot,
  output pra_pkg::pra_lane_in_t [19:0] lane_in
);
  always_comb begin
    for (int i = 0; i < PRA_LANES; i++) begin
      lane_in[i].word_sync = sync_m[i];
      lane_in[i].marker_seen = mark_m[i];
      lane_in[i].block_lock = lock_m[i];
      lane_in[i].marker_bad = bad_m[i];
      lane_in[i].marker_good = good_m[i];
      // Rotated map so each lane carries a distinct index
      lane_in[i].phys_idx = 5'((i + rot) % PRA_LANES);
    end
  end
endmodule

// *** sim/pra_status_tb_top.sv ***
// Testbench for the receive lane alignment status block
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module pra_status_tb_top;
  import pra_pkg::*;
  logic clk = 1'h0;
  logic rstn;
  logic [19:0] lock_m = 20'h0, sync_m = 20'h0, mark_m = 20'h0, good_m = 20'h0, bad_m = 20'h0;
  logic [4:0] rot = 5'h00;
  logic al = 1'h0, dsk = 1'h0, fail = 1'h0, miss = 1'h0, tick = 1'h0, hb = 1'h0, rf = 1'h0;
  logic [19:0] mfe, blk, wsync;
  logic [19:0][4:0] pidx;
  logic o_al, o_lf, o_st, o_ae, o_mis, o_rf;
  pra_lane_in_t [19:0] lane_in;
  int bad_count = 0;
  int n_compared = 0;
  pra_link_model i_link (.lock_m(lock_m), .sync_m(sync_m), .mark_m(mark_m), .good_m(good_m), .bad_m(bad_m),
    .rot(rot), .lane_in(lane_in));
  pra_status i_dut (.clk(clk), .rstn(rstn), .lane_in(lane_in), .lanes_aligned(al), .lanes_deskewed(dsk),
    .align_fail(fail), .aligner_marker_miss(miss), .metaframe_tick(tick), .hi_ber(hb), .remote_fault_det(rf),
    .lane_marker_word_error(mfe), .lane_block_lock(blk), .lane_word_sync(wsync), .pcs_lane_physical_index(pidx),
    .rx_aligned(o_al), .rx_local_fault(o_lf), .rx_status(o_st), .rx_aligned_err(o_ae), .rx_misaligned(o_mis),
    .rx_remote_fault(o_rf));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task step;
    @(posedge clk);
    #1;
  endtask
  task wrap_up;
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Inputs busy during reset, so a leak would show
  task do_reset;
    rstn = 1'h0;
    {al, dsk, fail, miss, tick, hb, rf} = 7'h7F;
    {lock_m, sync_m, mark_m, good_m, bad_m} = {5{20'hFFFFF}};
    rot = 5'h07;
    repeat (8) step;
    `CHK({mfe, blk, wsync, pidx, o_al, o_lf, o_st, o_ae, o_mis, o_rf}, '0);
    {al, dsk, fail, miss, tick, hb, rf} = 7'h00;
    {lock_m, sync_m, mark_m, good_m, bad_m} = 100'h0;
    rstn = 1'h1;
  endtask
  task t_levels;
    for (int k = 0; k < 8; k++) begin
      lock_m = 20'h5A3C1 << k;
      sync_m = ~lock_m;
      mark_m = 20'hFF0F3 >> k;
      rot = 5'(k * 3);
      al = k[0];
      dsk = k[1];
      hb = k[2];
      rf = k[1] ^ k[2];
      step;
      `CHK(blk, lock_m);
      `CHK(wsync, sync_m & mark_m);
      `CHK(o_al, al & dsk);
      `CHK(o_lf, ~(al & dsk));
      `CHK(o_st, al & dsk & ~hb);
      `CHK(o_rf, rf);
      for (int i = 0; i < 20; i++) begin
        if (wsync[i] === 1'h1) `CHK(pidx[i], 5'((i + rot) % 20));
      end
    end
  endtask
  // Never armed: lane errors show, misalignment stays quiet
  task t_marker;
    logic [19:0] pat [4];
    pat = '{20'h00008, 20'h00008, 20'h80001, 20'h00000};
    for (int j = 0; j < 4; j++) begin
      bad_m = pat[j];
      miss = (j < 3);
      tick = 1'h1;
      step;
      `CHK(mfe, pat[j]);
      `CHK(o_mis, 1'h0);
    end
    tick = 1'h0;
  endtask
  task t_align_err;
    fail = 1'h1;
    step;
    `CHK(o_ae, 1'h1);
    fail = 1'h0;
    step;
    `CHK(o_ae, 1'h0);
    {al, dsk} = 2'h3;
    step;
    `CHK(o_ae, 1'h0);
    dsk = 1'h0;
    step;
    `CHK(o_ae, 1'h1);
  endtask
  task t_misalign;
    good_m = 20'hFFFFF;
    step;
    good_m = 20'h0;
    miss = 1'h1;
    step;
    {miss, tick} = 2'h1;
    repeat (2) begin
      step;
      tick = 1'h0;
      `CHK(o_mis, 1'h0);
    end
    {miss, tick} = 2'h3;
    bad_m = 20'h00001;
    for (int j = 0; j < 5; j++) begin
      step;
      {miss, tick, bad_m} = 22'h0;
      `CHK(o_mis, 1'h0);
    end
    tick = 1'h1;
    step;
    tick = 1'h0;
    `CHK(o_mis, 1'h1);
    step;
    `CHK(o_mis, 1'h0);
  endtask
  initial begin
    #1000000;
    bad_count++;
    wrap_up;
  end
  initial begin
    // Reset falls from unknown after the flops wait, so the async branch fires
    #1;
    do_reset;
    t_levels;
    do_reset;
    t_marker;
    do_reset;
    t_align_err;
    do_reset;
    t_misalign;
    wrap_up;
  end
endmodule
